// ### design/wdt_pkg.sv
package wdt_pkg;

    // ----------------------------------------
    // register map (byte addresses, one word each)
    // ----------------------------------------
    localparam int ADDR_W = 8;                        // decoded address bits
    localparam logic [7:0] OFS_LOAD = 8'h00;          // reload value
    localparam logic [7:0] OFS_VALUE = 8'h04;         // live counter, read only
    localparam logic [7:0] OFS_CTRL = 8'h08;          // enable, reset option, stall
    localparam logic [7:0] OFS_INTCLR = 8'h0C;        // write clears timeout int
    localparam logic [7:0] OFS_RIS = 8'h10;           // raw timeout int
    localparam logic [7:0] OFS_MIS = 8'h14;           // enable-masked timeout int
    localparam logic [7:0] OFS_LOCK = 8'h18;          // key unlocks, else locks
    localparam logic [7:0] OFS_STATUS = 8'h1C;        // running, locked
    localparam logic [7:0] OFS_EVT = 8'h20;           // sticky events, read clears
    localparam logic [7:0] OFS_EVTMASK = 8'h24;       // event mask

    // ----------------------------------------
    // field positions and reset values
    // ----------------------------------------
    localparam int CTRL_EN_BIT = 0;                   // counter enable
    localparam int CTRL_RST_BIT = 1;                  // reset on second timeout
    localparam int CTRL_STALL_BIT = 2;                // freeze while debug halted
    localparam int STAT_RUN_BIT = 0;                  // running flag
    localparam int STAT_LOCK_BIT = 1;                 // lock flag
    localparam int EVT_W = 3;                         // number of events
    localparam int EVT_TIMEOUT = 0;                   // counter reached zero
    localparam int EVT_SECOND = 1;                    // unserviced second timeout
    localparam int EVT_LOCKWR = 2;                    // write refused by lock
    localparam logic [31:0] LOAD_RST = 32'hFFFF_FFFF; // reload after reset
    localparam logic [31:0] UNLOCK_KEY = 32'h1ACC_E551; // arbitrary value

    // ----------------------------------------
    // bus answers
    // ----------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;          // accepted
    localparam logic [1:0] RESP_SLVERR = 2'h2;        // unmapped address

    // ----------------------------------------
    // carriers between bus slave and core
    // ----------------------------------------
    typedef struct packed {
        logic en;                                     // one-cycle write pulse
        logic [ADDR_W-1:0] addr;                      // byte address
        logic [31:0] data;                            // write data
        logic [3:0] strb;                             // byte enables
    } wr_req_t;

    typedef struct packed {
        logic en;                                     // one-cycle read pulse
        logic [ADDR_W-1:0] addr;                      // byte address
    } rd_req_t;

endpackage : wdt_pkg

// ### design/halt_sync.sv
`timescale 1ns/100ps
module halt_sync
    import wdt_pkg::*;
(
    input wire logic aclk,     // system clock
    input wire logic aresetn,  // synchronous reset, active low
    input wire logic async_in, // level from another domain
    output logic sync_out      // filtered level
);
    // ----------------------------------------
    // three stage chain
    // ----------------------------------------
    logic s1_q; // metastable stage, read only by s2
    logic s2_q; // second stage
    logic s3_q; // third stage

    // shift the pin through three flops
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= async_in;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // a change counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_out <= 1'b0;
        end else if (s2_q == s3_q) begin
            sync_out <= s3_q;
        end
    end
endmodule : halt_sync

// ### design/axil_slave.sv
`timescale 1ns/100ps
module axil_slave
    import wdt_pkg::*;
(
    input wire logic aclk,           // system clock
    input wire logic aresetn,        // synchronous reset, active low
    input wire logic [31:0] awaddr,  // write address
    input wire logic awvalid,        // write address valid
    output logic awready,            // write address ready
    input wire logic [31:0] wdata,   // write data
    input wire logic [3:0] wstrb,    // write strobes
    input wire logic wvalid,         // write data valid
    output logic wready,             // write data ready
    output logic [1:0] bresp,        // write response
    output logic bvalid,             // write response valid
    input wire logic bready,         // write response ready
    input wire logic [31:0] araddr,  // read address
    input wire logic arvalid,        // read address valid
    output logic arready,            // read address ready
    output logic [31:0] rdata,       // read data
    output logic [1:0] rresp,        // read response
    output logic rvalid,             // read data valid
    input wire logic rready,         // read data ready
    output wr_req_t wr,              // write pulse to core
    output rd_req_t rd,              // read pulse to core
    input wire logic [31:0] rd_data, // core read data
    input wire logic rd_err,         // core says unmapped
    input wire logic wr_err          // core says unmapped
);
    // ----------------------------------------
    // write channel
    // ----------------------------------------
    logic aw_full_q;              // address held
    logic w_full_q;               // data held
    logic [ADDR_W-1:0] aw_addr_q; // held address
    logic [31:0] w_data_q;        // held data
    logic [3:0] w_strb_q;         // held strobes
    logic do_wr;                  // both halves present

    assign do_wr = aw_full_q && w_full_q && !bvalid;
    assign wr = '{en: do_wr, addr: aw_addr_q, data: w_data_q, strb: w_strb_q};

    // address and data are taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= '0;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
        end else begin
            if (awvalid && awready) begin
                aw_full_q <= 1'b1;
                aw_addr_q <= awaddr[ADDR_W-1:0];
            end else if (do_wr) begin
                aw_full_q <= 1'b0;
            end
            if (wvalid && wready) begin
                w_full_q <= 1'b1;
                w_data_q <= wdata;
                w_strb_q <= wstrb;
            end else if (do_wr) begin
                w_full_q <= 1'b0;
            end
        end
    end

    // readies are flops; a held half blocks its channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            wready <= 1'b0;
        end else begin
            awready <= !(aw_full_q || (awvalid && awready)) || do_wr;
            wready <= !(w_full_q || (wvalid && wready)) || do_wr;
        end
    end

    // response follows the performed write by one cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
        end else if (do_wr) begin
            bvalid <= 1'b1;
            bresp <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // ----------------------------------------
    // read channel
    // ----------------------------------------
    assign rd = '{en: arvalid && arready, addr: araddr[ADDR_W-1:0]};

    // data is captured at the address handshake, so read side effects happen once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= RESP_OKAY;
        end else if (rd.en) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= rd_data;
            rresp <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end else begin
            arready <= !rvalid;
        end
    end
endmodule : axil_slave

// ### design/watchdog_timer_control.sv
`timescale 1ns/100ps
// Functional notes
// - reset option: second timeout resets processor
// - reset option off: no processor reset
// - locked: reload, reset option, enable unchanged
// - unlock restores configuration write access
// - stall on: hold count while halted
// - stall off: count regardless of halt
// - running flag readable
// - live counter readable, no side effect
// - first zero: reload and raise interrupt
// - reload write loads now; zero interrupts
// - clear drops interrupt; raw, masked readable
// - lock status readable
module watchdog_timer_control
    import wdt_pkg::*;
(
    input wire logic aclk,          // system clock, 250 MHz
    input wire logic aresetn,       // synchronous reset, active low
    input wire logic [31:0] awaddr, // write address
    input wire logic awvalid,       // write address valid
    output logic awready,           // write address ready
    input wire logic [31:0] wdata,  // write data
    input wire logic [3:0] wstrb,   // write strobes
    input wire logic wvalid,        // write data valid
    output logic wready,            // write data ready
    output logic [1:0] bresp,       // write response
    output logic bvalid,            // write response valid
    input wire logic bready,        // write response ready
    input wire logic [31:0] araddr, // read address
    input wire logic arvalid,       // read address valid
    output logic arready,           // read address ready
    output logic [31:0] rdata,      // read data
    output logic [1:0] rresp,       // read response
    output logic rvalid,            // read data valid
    input wire logic rready,        // read data ready
    input wire logic debug_halt,    // processor halted by debugger
    output logic irq_q,             // level interrupt
    output logic proc_reset_q       // processor reset request
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // byte-lane merge used by the reload, control and event mask registers
    function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[8*i +: 8] = new_v[8*i +: 8];
            end
        end
        return r;
    endfunction : merge

    // ----------------------------------------
    // state
    // ----------------------------------------
    wr_req_t wr;                  // write pulse from bus
    rd_req_t rd;                  // read pulse from bus
    logic [31:0] rd_data;         // read mux
    logic rd_err;                 // unmapped read
    logic wr_err;                 // unmapped write
    logic halt_s;                 // synchronised halt
    logic en_q;                   // counter enable
    logic rst_en_q;               // reset option
    logic stall_q;                // debug stall option
    logic lock_q;                 // configuration locked
    logic [31:0] load_q;          // reload value
    logic [31:0] count_q;         // down counter
    logic ris_q;                  // raw timeout interrupt
    logic [EVT_W-1:0] evt_q;      // sticky events
    logic [EVT_W-1:0] mask_q;     // event mask
    logic [31:0] ctrl_new;        // merged control word
    logic [31:0] load_new;        // merged reload word
    logic [31:0] mask_new;        // merged event mask word
    logic tick;                   // counter advances this cycle
    logic at_zero;                // timeout this cycle
    logic second;                 // unserviced timeout
    logic ld_wr;                  // accepted reload write
    logic ctrl_wr;                // accepted control write
    logic cfg_try;                // configuration write attempt
    logic clr_wr;                 // interrupt clear write
    logic [EVT_W-1:0] evt_set;    // events this cycle

    // ----------------------------------------
    // bus slave and halt synchroniser
    // ----------------------------------------
    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(awaddr),
        .awvalid(awvalid),
        .awready(awready),
        .wdata(wdata),
        .wstrb(wstrb),
        .wvalid(wvalid),
        .wready(wready),
        .bresp(bresp),
        .bvalid(bvalid),
        .bready(bready),
        .araddr(araddr),
        .arvalid(arvalid),
        .arready(arready),
        .rdata(rdata),
        .rresp(rresp),
        .rvalid(rvalid),
        .rready(rready),
        .wr(wr),
        .rd(rd),
        .rd_data(rd_data),
        .rd_err(rd_err),
        .wr_err(wr_err)
    );

    halt_sync u_halt (
        .aclk(aclk),
        .aresetn(aresetn),
        .async_in(debug_halt),
        .sync_out(halt_s)
    );

    // ----------------------------------------
    // write decode
    // ----------------------------------------
    assign cfg_try = wr.en && (wr.addr == OFS_LOAD || wr.addr == OFS_CTRL);
    assign ld_wr = wr.en && wr.addr == OFS_LOAD && !lock_q;
    assign ctrl_wr = wr.en && wr.addr == OFS_CTRL && !lock_q;
    assign clr_wr = wr.en && wr.addr == OFS_INTCLR;
    assign ctrl_new = merge({29'h0, stall_q, rst_en_q, en_q}, wr.data, wr.strb);
    assign load_new = merge(load_q, wr.data, wr.strb);
    // a call result cannot be part-selected, so the mask is merged as a full word here
    assign mask_new = merge(32'(mask_q), wr.data, wr.strb);

    // every mapped offset answers okay, even when the lock refuses it
    always_comb begin
        case (wr.addr)
            OFS_LOAD, OFS_VALUE, OFS_CTRL, OFS_INTCLR, OFS_RIS, OFS_MIS,
            OFS_LOCK, OFS_STATUS, OFS_EVT, OFS_EVTMASK: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    // ----------------------------------------
    // configuration
    // ----------------------------------------
    // controls, writable only while unlocked
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            en_q <= 1'b0;
            rst_en_q <= 1'b0;
            stall_q <= 1'b0;
        end else if (ctrl_wr) begin
            en_q <= ctrl_new[CTRL_EN_BIT];
            rst_en_q <= ctrl_new[CTRL_RST_BIT];
            stall_q <= ctrl_new[CTRL_STALL_BIT];
        end
    end

    // reload value
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            load_q <= LOAD_RST;
        end else if (ld_wr) begin
            load_q <= load_new;
        end
    end

    // the key opens the block; any other word written here closes it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lock_q <= 1'b0;
        end else if (wr.en && wr.addr == OFS_LOCK) begin
            lock_q <= (wr.data != UNLOCK_KEY);
        end
    end

    // ----------------------------------------
    // counter
    // ----------------------------------------
    assign tick = en_q && !(stall_q && halt_s);
    assign at_zero = tick && count_q == 32'h0000_0000;
    assign second = at_zero && ris_q && !clr_wr;

    // a reload write wins over counting; enabling starts from the reload
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_q <= LOAD_RST;
        end else if (ld_wr) begin
            count_q <= load_new;
        end else if (ctrl_wr && !en_q && ctrl_new[CTRL_EN_BIT]) begin
            count_q <= load_q;
        end else if (at_zero) begin
            count_q <= load_q;
        end else if (tick) begin
            count_q <= count_q - 32'h0000_0001;
        end
    end

    // timeout flag; a new timeout in the clearing cycle survives
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ris_q <= 1'b0;
        end else if (at_zero || (ld_wr && load_new == 32'h0000_0000)) begin
            ris_q <= 1'b1;
        end else if (clr_wr) begin
            ris_q <= 1'b0;
        end
    end

    // held until system reset, which the request itself brings about
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            proc_reset_q <= 1'b0;
        end else if (second && rst_en_q) begin
            proc_reset_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // events and interrupt
    // ----------------------------------------
    assign evt_set[EVT_TIMEOUT] = at_zero;
    assign evt_set[EVT_SECOND] = second;
    assign evt_set[EVT_LOCKWR] = cfg_try && lock_q;

    // sticky; reading the event word clears, but a set in that cycle wins
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            evt_q <= '0;
        end else if (rd.en && rd.addr == OFS_EVT) begin
            evt_q <= evt_set;
        end else begin
            evt_q <= evt_q | evt_set;
        end
    end

    // event mask, not covered by the lock
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mask_q <= '0;
        end else if (wr.en && wr.addr == OFS_EVTMASK) begin
            mask_q <= mask_new[EVT_W-1:0];
        end
    end

    // one cycle behind the sticky event bits, kept registered for a clean output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(evt_q & mask_q);
        end
    end

    // ----------------------------------------
    // read mux
    // ----------------------------------------
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_err = 1'b0;
        case (rd.addr)
            OFS_LOAD: rd_data = load_q;
            OFS_VALUE: rd_data = count_q;
            OFS_CTRL: rd_data = {29'h0, stall_q, rst_en_q, en_q};
            OFS_INTCLR: rd_data = 32'h0000_0000;
            OFS_RIS: rd_data = {31'h0, ris_q};
            OFS_MIS: rd_data = {31'h0, ris_q && en_q};
            OFS_LOCK: rd_data = {31'h0, lock_q};
            OFS_STATUS: begin
                rd_data[STAT_RUN_BIT] = en_q;
                rd_data[STAT_LOCK_BIT] = lock_q;
            end
            OFS_EVT: rd_data = 32'(evt_q);
            OFS_EVTMASK: rd_data = 32'(mask_q);
            default: rd_err = 1'b1;
        endcase
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_second_reset: assert property (
        second && rst_en_q |=> proc_reset_q ##1 proc_reset_q)
        else $error("second timeout did not reset");

    chk_no_reset: assert property (
        !rst_en_q && !proc_reset_q && !ctrl_wr |=> !proc_reset_q)
        else $error("reset issued with option off");

    chk_lock_hold: assert property (
        lock_q && cfg_try |=> $stable(load_q) && $stable(en_q) && $stable(rst_en_q))
        else $error("locked configuration changed");

    chk_unlock_write: assert property (
        !lock_q && wr.en && wr.addr == OFS_LOAD && wr.strb == 4'hF
        |=> load_q == $past(wr.data))
        else $error("write refused after unlock");

    chk_stall_hold: assert property (
        en_q && stall_q && halt_s && !ld_wr && !ctrl_wr |=> count_q == $past(count_q))
        else $error("counter moved while stalled");

    chk_free_run: assert property (
        en_q && !stall_q && count_q != 0 && !ld_wr && !ctrl_wr
        |=> count_q == $past(count_q) - 32'h0000_0001)
        else $error("counter did not decrement");

    chk_zero_reload: assert property (
        at_zero && !ld_wr |=> count_q == load_q && ris_q)
        else $error("zero did not reload and interrupt");

    chk_load_zero: assert property (
        ld_wr && load_new == 32'h0000_0000 |=> ris_q && count_q == 32'h0000_0000)
        else $error("zero reload raised no interrupt");

    chk_int_clear: assert property (
        clr_wr && !at_zero && !ld_wr |=> !ris_q)
        else $error("clear left interrupt set");

    chk_irq_level: assert property (
        |(evt_q & mask_q) |=> irq_q)
        else $error("irq low with unmasked event");

    // read words are checked one cycle on, where the captured word stands
    chk_status_read: assert property (
        rd.en && rd.addr == OFS_STATUS
        |=> rdata[STAT_RUN_BIT] == $past(en_q) && rdata[STAT_LOCK_BIT] == $past(lock_q))
        else $error("status word wrong");

    chk_value_read: assert property (
        rd.en && rd.addr == OFS_VALUE
        |=> rdata == $past(count_q))
        else $error("counter read wrong");

    cov_reset_issued: cover property (second && rst_en_q ##1 proc_reset_q);
    cov_stalled: cover property (en_q && stall_q && halt_s [*3]);
    cov_locked_write: cover property (cfg_try && lock_q);
    cov_second_silent: cover property (second && !rst_en_q);
    cov_irq_cleared: cover property (irq_q ##1 rd.en && rd.addr == OFS_EVT);
endmodule : watchdog_timer_control

// ### bench/tb_top.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin errors++; \
    $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb_top
    import wdt_pkg::*;
;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, debug_halt; // bench drives
    logic awready, wready, bvalid, arready, rvalid, irq_q, proc_reset_q; // design answers
    logic [31:0] awaddr, wdata, araddr, rdata, dv, lv, dd; // bus words
    logic [3:0] wstrb; // byte lanes
    logic [1:0] bresp, rresp, rr; // responses
    int errors, n_tests; // tallies
    int unsigned cyc, tk, dt; // cycle stamps
    watchdog_timer_control i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .debug_halt, .irq_q, .proc_reset_q);
    // ----------------------------------------
    // clock, stamps, bus tasks
    // ----------------------------------------
    initial begin
        aclk = 0;
        forever #2 aclk = ~aclk;
    end
    always @(posedge aclk) cyc <= cyc + 1;
    function automatic logic [31:0] stat_exp(input logic en, input logic lk);
        return {30'h0, lk, en};
    endfunction : stat_exp
    // both halves offered together, each dropped at its own handshake
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ad, wd;
        ad = 0;
        wd = 0;
        awaddr <= {24'h0, a};
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge aclk);
            if (awready && !ad) begin ad = 1; awvalid <= 0; end
            if (wready && !wd) begin wd = 1; wvalid <= 0; end
        end while (!(ad && wd));
        do @(posedge aclk); while (!bvalid);
        `CHK("bresp", RESP_OKAY, bresp)
    endtask : wr
    // data taken at the edge where rvalid is seen; tk stamps the address edge
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        araddr <= {24'h0, a};
        arvalid <= 1;
        do @(posedge aclk); while (!arready);
        tk = cyc;
        arvalid <= 0;
        do @(posedge aclk); while (!rvalid);
        d = rdata;
        r = rresp;
    endtask : rd
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a, dd, rr);
        `CHK(nm, e, dd)
    endtask : rchk
    // two counter reads: drop in value and cycles between them
    task automatic pair();
        int unsigned t0;
        logic [31:0] v0;
        rd(OFS_VALUE, v0, rr);
        t0 = tk;
        rd(OFS_VALUE, dv, rr);
        dv = v0 - dv;
        dt = tk - t0;
    endtask : pair
    task automatic do_reset();
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
    endtask : do_reset
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : tally_and_finish
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {aresetn, awvalid, wvalid, arvalid, debug_halt, cyc} = 0;
        {awaddr, wdata, araddr} = 0;
        {bready, rready, wstrb} = {2'b11, 4'hf};
        {errors, n_tests} = 0;
        void'($urandom(32'h5a65));
        lv = $urandom_range(40, 16);
        do_reset();
        rchk(OFS_STATUS, stat_exp(0, 0), "status");
        rchk(OFS_VALUE, LOAD_RST, "value");
        wr(OFS_LOCK, $urandom() ^ UNLOCK_KEY | 32'h2); // any non-key locks
        rchk(OFS_LOCK, 32'h1, "lock");
        wr(OFS_CTRL, 32'h7);
        wr(OFS_LOAD, lv);
        rchk(OFS_CTRL, 32'h0, "ctrl");
        rchk(OFS_LOAD, LOAD_RST, "load");
        rchk(OFS_STATUS, stat_exp(0, 1), "status");
        wr(OFS_LOCK, UNLOCK_KEY);
        wr(OFS_LOAD, lv);
        rchk(OFS_VALUE, lv, "value");
        wr(OFS_EVTMASK, 32'h1);
        wr(OFS_CTRL, 32'h1);
        rchk(OFS_STATUS, stat_exp(1, 0), "status");
        // at least three timeouts pass unserviced with the reset option off
        repeat (3 * lv + 40) @(posedge aclk);
        `CHK("proc_reset", 1'b0, proc_reset_q)
        `CHK("irq", 1'b1, irq_q)
        rd(OFS_VALUE, dv, rr);
        `CHK("reload", 1'b1, dv <= lv)
        rchk(OFS_MIS, 32'h1, "mis");
        wr(OFS_EVTMASK, 32'h0);
        @(posedge aclk);
        `CHK("irq", 1'b0, irq_q)
        wr(OFS_CTRL, 32'h0);
        wr(OFS_INTCLR, 32'h0);
        rchk(OFS_RIS, 32'h0, "ris");
        rchk(OFS_EVT, 32'h7, "evt");
        rchk(OFS_EVT, 32'h0, "evt");
        wr(OFS_LOAD, 32'h0);
        rchk(OFS_RIS, 32'h1, "ris");
        rchk(OFS_MIS, 32'h0, "mis");
        // freeze under debug halt, then free running
        wr(OFS_LOAD, LOAD_RST);
        wr(OFS_CTRL, 32'h5);
        debug_halt <= 1;
        repeat (8) @(posedge aclk);
        pair();
        `CHK("stalled", 32'h0, dv)
        debug_halt <= 0;
        repeat (8) @(posedge aclk);
        pair();
        `CHK("resumed", dt, dv)
        wr(OFS_CTRL, 32'h1);
        debug_halt <= 1;
        repeat (8) @(posedge aclk);
        pair();
        `CHK("no stall", dt, dv)
        debug_halt <= 0;
        // second timeout with the reset option on
        wr(OFS_INTCLR, 32'h0);
        wr(OFS_LOAD, lv);
        wr(OFS_CTRL, 32'h3);
        repeat (lv + 4) @(posedge aclk);
        `CHK("proc_reset", 1'b0, proc_reset_q)
        repeat (lv + 18) @(posedge aclk);
        `CHK("proc_reset", 1'b1, proc_reset_q)
        do_reset();
        `CHK("proc_reset", 1'b0, proc_reset_q)
        rd(8'h40, dv, rr);
        `CHK("unmapped", RESP_SLVERR, rr)
        tally_and_finish();
    end
    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        tally_and_finish();
    end
endmodule : tb_top
